// ==== snpep_pkg.sv ====
// Purpose: Shared constants and types for the SPI NAND program, erase and protect block.
// Assumes: 1 Gbit array, 2112-byte cache, one-byte feature addresses.
// Notes: Every offset, reset value and count used by more than one place lives here.
package snpep_pkg;
   // ---------------------------------------------------------------
   // Clock and array geometry.
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 8;
   localparam logic [11:0] CACHE_BYTES = 12'h840;
   localparam logic [11:0] UID_SPAN = 12'h200;
   localparam logic [10:0] BLOCK_COUNT = 11'h400;
   localparam logic [10:0] FRACTION_MIN = 11'h010;
   localparam logic [7:0] OTP_FIRST = 8'h02;
   localparam logic [7:0] OTP_LAST = 8'h1F;
   // ---------------------------------------------------------------
   // Opcodes.
   // ---------------------------------------------------------------
   localparam logic [7:0] OP_WRITE_EN = 8'h06;
   localparam logic [7:0] OP_WRITE_DIS = 8'h04;
   localparam logic [7:0] OP_GETF = 8'h0F;
   localparam logic [7:0] OP_SETF = 8'h1F;
   localparam logic [7:0] OP_LOAD = 8'h02;
   localparam logic [7:0] OP_LOAD_Q = 8'h32;
   localparam logic [7:0] OP_RAND = 8'h84;
   localparam logic [7:0] OP_RAND_Q = 8'h34;
   localparam logic [7:0] OP_EXEC = 8'h10;
   localparam logic [7:0] OP_ERASE = 8'hD8;
   localparam logic [7:0] OP_PREAD = 8'h13;
   localparam logic [7:0] OP_RDC = 8'h03;
   localparam logic [7:0] OP_RDC_F = 8'h0B;
   // ---------------------------------------------------------------
   // Feature addresses, reset values and writable masks.
   // ---------------------------------------------------------------
   localparam logic [7:0] FA_LOCK = 8'hA0;
   localparam logic [7:0] FA_OTP = 8'hB0;
   localparam logic [7:0] FA_STAT = 8'hC0;
   localparam logic [7:0] LOCK_RESET = 8'h3E;
   localparam logic [7:0] LOCK_MASK = 8'hBE;
   localparam logic [7:0] OTP_RESET = 8'h10;
   localparam logic [7:0] OTP_MASK = 8'hD1;
   // ---------------------------------------------------------------
   // AXI4-Lite map.
   // ---------------------------------------------------------------
   localparam logic [7:0] A_STATUS = 8'h00;
   localparam logic [7:0] A_UID0 = 8'h10;
   localparam logic [2:0] IDX_NONE = 3'h7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ---------------------------------------------------------------
   // Types.
   // ---------------------------------------------------------------
   typedef struct packed {
      logic guard;
      logic rsv6;
      logic [2:0] range;
      logic invert;
      logic complement;
      logic rsv0;
   } snpep_lock_t;
   typedef struct packed {
      logic otpLockBit;
      logic access;
      logic rsv5;
      logic eccEnable;
      logic [2:0] rsv3;
      logic quadIoEnable;
   } snpep_otp_t;
   typedef struct packed {
      logic [1:0] rsv6;
      logic [1:0] eccState;
      logic progFail;
      logic eraseFail;
      logic writeLatchFlag;
      logic operationBusyFlag;
   } snpep_status_t;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_PROG = 4'h2,
      ST_ERASE = 4'h4,
      ST_READ = 4'h8
   } snpep_state_t;
endpackage

// ==== snpep_top.sv ====
// Purpose: Device-side command engine for program, erase, lock and OTP of an SPI NAND.
// Assumes: SPI mode 0, sclk well below mclk/4, host keeps its own sequencing duties.
`timescale 1ns/10ps
module snpep_top
   import snpep_pkg::*;
#(
   parameter int PROG_TIME_NS = 300000,
   parameter int ERASE_TIME_NS = 3000000,
   parameter int READ_TIME_NS = 50000,
   parameter int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS,
   parameter int ERASE_CYCLES = ERASE_TIME_NS / CLK_PERIOD_NS,
   parameter int READ_CYCLES = READ_TIME_NS / CLK_PERIOD_NS,
   // Unique identifier value is arbitrary.
   parameter logic [127:0] UID_INIT = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210
)(
   // System.
   input wire logic mclk,
   input wire logic rst,
   // SPI link.
   input wire logic csN,
   input wire logic sclk,
   input wire logic wpN,
   input wire logic [3:0] sioIn,
   output logic sioOut,
   output logic sioOe,
   // AXI4-Lite write.
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read.
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // ---------------------------------------------------------------
   // Helpers.
   // ---------------------------------------------------------------
   function automatic logic isQuad(input logic [7:0] op);
      return op == OP_LOAD_Q || op == OP_RAND_Q;
   endfunction

   function automatic logic [2:0] axiIdx(input logic [7:0] a);
      if (a == A_STATUS) return 3'h0;
      if (a[7:4] == A_UID0[7:4] && a[1:0] == 2'h0) return {1'b0, a[3:2]} + 3'h1;
      return IDX_NONE;
   endfunction

   function automatic logic blockLocked(input snpep_lock_t l, input logic [9:0] blk);
      logic [10:0] size;
      logic inRegion;
      size = FRACTION_MIN << (l.range - 3'h1);
      inRegion = l.invert ? ({1'b0, blk} < size) : ({1'b0, blk} >= BLOCK_COUNT - size);
      if (l.range == 3'h0) return 1'b0;
      if (l.range == 3'h7) return 1'b1;
      if (l.complement && l.range == 3'h6) return blk == 10'h000;
      return l.complement ? !inRegion : inRegion;
   endfunction

   // ---------------------------------------------------------------
   // Signals.
   // ---------------------------------------------------------------
   logic [1:0] csS, sclkS, wpS;
   logic [3:0] sioA, sioB;
   logic sclkD, sclkRise, sclkFall, frameOn;
   logic [7:0] shift, next_shift, rxByte, cmd, addrHi, rowHi, featByte, rdData;
   logic [3:0] bitCnt, step;
   logic [2:0] idx;
   logic rxDone, quadPh, loadOk, txOn, idle, isOp, isRead;
   logic cmdByte, featWr, opCap, dataByte, rdStep, rowLocked;
   logic [11:0] col;
   logic [15:0] row;
   logic [7:0] cache [CACHE_BYTES];
   snpep_lock_t lockReg;
   snpep_otp_t otpReg;
   snpep_status_t stat;
   snpep_state_t state;
   logic [23:0] busyCnt;
   logic write_latch_flag, eFail, pFail, uidSel, otpSealed;
   logic [7:0] otpNext;
   logic [7:0] txReg;
   logic [127:0] uid;
   logic [7:0] awAddr;
   logic [31:0] wData;
   logic [3:0] wStrb;
   logic awHave, wHave;
   logic [2:0] wIdx;

   // ---------------------------------------------------------------
   // Pin synchronisers and edge detection.
   // ---------------------------------------------------------------
   // Data and clock share the same two-stage delay, so a detected rise sees matching data.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         csS <= 2'h3;
         wpS <= 2'h3;
         sclkS <= 2'h0;
         sclkD <= 1'b0;
         sioA <= 4'h0;
         sioB <= 4'h0;
      end else begin
         csS <= {csS[0], csN};
         wpS <= {wpS[0], wpN};
         sclkS <= {sclkS[0], sclk};
         sclkD <= sclkS[1];
         sioA <= sioIn;
         sioB <= sioA;
      end
   end

   assign sclkRise = sclkS[1] & ~sclkD;
   assign sclkFall = ~sclkS[1] & sclkD;
   assign frameOn = ~csS[1];

   // ---------------------------------------------------------------
   // Receive shifter.
   // ---------------------------------------------------------------
   always_comb begin
      quadPh = isQuad(cmd) && idx >= 3'h3;
      step = quadPh ? 4'h4 : 4'h1;
      next_shift = quadPh ? {shift[3:0], sioB} : {shift[6:0], sioB[0]};
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         shift <= 8'h00;
         bitCnt <= 4'h0;
         rxDone <= 1'b0;
         rxByte <= 8'h00;
      end else begin
         rxDone <= 1'b0;
         if (!frameOn) begin
            bitCnt <= 4'h0;
         end else if (sclkRise) begin
            shift <= next_shift;
            if (bitCnt + step == 4'h8) begin
               bitCnt <= 4'h0;
               rxDone <= 1'b1;
               rxByte <= next_shift;
            end else begin
               bitCnt <= bitCnt + step;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Command decode.
   // ---------------------------------------------------------------
   always_comb begin
      idle = state == ST_IDLE;
      isOp = cmd == OP_EXEC || cmd == OP_ERASE || cmd == OP_PREAD;
      isRead = cmd == OP_RDC || cmd == OP_RDC_F;
      cmdByte = rxDone && idx == 3'h0;
      featWr = rxDone && idx == 3'h2 && cmd == OP_SETF && idle;
      opCap = rxDone && idx == 3'h3 && isOp && idle;
      dataByte = rxDone && idx >= 3'h3 && loadOk;
      rdStep = rxDone && isRead && ((idx == 3'h3 && idle) || (idx > 3'h3 && txOn));
      row = {rowHi, rxByte};
      rowLocked = blockLocked(lockReg, row[15:6]);
   end

   // ---------------------------------------------------------------
   // Frame state.
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         idx <= 3'h0;
         cmd <= 8'h00;
         addrHi <= 8'h00;
         rowHi <= 8'h00;
         col <= 12'h000;
         loadOk <= 1'b0;
      end else if (!frameOn) begin
         idx <= 3'h0;
         loadOk <= 1'b0;
      end else if (rxDone) begin
         if (idx != 3'h7) idx <= idx + 3'h1;
         if (idx == 3'h0) begin
            cmd <= rxByte;
            loadOk <= (rxByte == OP_LOAD || rxByte == OP_RAND || isQuad(rxByte)) && write_latch_flag
               && idle && (otpReg.quadIoEnable || !isQuad(rxByte));
         end
         if (idx == 3'h1) addrHi <= rxByte;
         if (idx == 3'h2) rowHi <= rxByte;
         if (idx == 3'h2) begin
            col <= {addrHi[3:0], rxByte};
         end else if ((dataByte || rdStep) && col != 12'hFFF) begin
            col <= col + 12'h001;
         end
      end
   end

   // Stores only what lands inside the cache; later bytes of a long load fall away.
   always_ff @(posedge mclk) begin
      if (dataByte && col < CACHE_BYTES) cache[col] <= rxByte;
   end

   // ---------------------------------------------------------------
   // Feature registers.
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         lockReg <= snpep_lock_t'(LOCK_RESET);
         otpReg <= snpep_otp_t'(OTP_RESET);
      end else if (featWr) begin
         if (addrHi == FA_LOCK && !(lockReg.guard && !wpS[1])) begin
            lockReg <= snpep_lock_t'(rxByte & LOCK_MASK);
         end else if (addrHi == FA_OTP) begin
            otpReg <= snpep_otp_t'(rxByte & OTP_MASK);
         end
      end
   end

   always_comb begin
      stat = '0;
      stat.progFail = pFail;
      stat.eraseFail = eFail;
      stat.writeLatchFlag = write_latch_flag;
      stat.operationBusyFlag = !idle;
   end

   // ---------------------------------------------------------------
   // Array operation sequencer.
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state <= ST_IDLE;
         busyCnt <= 24'h00_0000;
         write_latch_flag <= 1'b0;
         eFail <= 1'b0;
         pFail <= 1'b0;
         uidSel <= 1'b0;
         otpSealed <= 1'b0;
         otpNext <= OTP_FIRST;
      end else begin
         if (cmdByte && idle && rxByte == OP_WRITE_EN) write_latch_flag <= 1'b1;
         if (cmdByte && idle && rxByte == OP_WRITE_DIS) write_latch_flag <= 1'b0;
         if (dataByte) uidSel <= 1'b0;
         if (!idle) begin
            if (busyCnt <= 24'h00_0001) begin
               state <= ST_IDLE;
               if (state != ST_READ) write_latch_flag <= 1'b0;
            end else begin
               busyCnt <= busyCnt - 24'h00_0001;
            end
         end
         if (opCap && cmd == OP_PREAD) begin
            state <= ST_READ;
            busyCnt <= 24'(READ_CYCLES);
            uidSel <= otpReg.access && row == 16'h0000;
         end
         if (opCap && cmd == OP_ERASE && write_latch_flag) begin
            eFail <= 1'b0;
            if (rowLocked) begin
               eFail <= 1'b1;
               write_latch_flag <= 1'b0;
            end else begin
               state <= ST_ERASE;
               busyCnt <= 24'(ERASE_CYCLES);
            end
         end
         if (opCap && cmd == OP_EXEC && write_latch_flag) begin
            pFail <= 1'b0;
            if (otpReg.access && otpReg.otpLockBit && !otpSealed) begin
               otpSealed <= 1'b1;
               state <= ST_PROG;
               busyCnt <= 24'(PROG_CYCLES);
            end else if (otpReg.access ? (otpSealed || row[15:8] != 8'h00
                  || row[7:0] < otpNext || row[7:0] > OTP_LAST) : rowLocked) begin
               pFail <= 1'b1;
               write_latch_flag <= 1'b0;
            end else begin
               state <= ST_PROG;
               busyCnt <= 24'(PROG_CYCLES);
               if (otpReg.access) otpNext <= row[7:0] + 8'h01;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Transmit path.
   // ---------------------------------------------------------------
   always_comb begin
      featByte = 8'h00;
      unique case (idx == 3'h1 ? rxByte : addrHi)
         FA_LOCK: featByte = lockReg;
         FA_OTP: featByte = otpReg;
         FA_STAT: featByte = stat;
         default: featByte = 8'h00;
      endcase
      if (uidSel) begin
         rdData = uid[{col[3:0], 3'h0} +: 8];
         if (col[4]) rdData = ~rdData;
         if (col >= UID_SPAN) rdData = 8'hFF;
      end else begin
         rdData = (col < CACHE_BYTES) ? cache[col] : 8'hFF;
      end
   end

   // Bytes are loaded on the byte boundary and shifted out on each falling edge.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         txReg <= 8'h00;
         txOn <= 1'b0;
         sioOut <= 1'b0;
         sioOe <= 1'b0;
      end else if (!frameOn) begin
         txOn <= 1'b0;
         sioOe <= 1'b0;
      end else begin
         if (rxDone && idx == 3'h1 && cmd == OP_GETF) txOn <= 1'b1;
         if (rdStep && idx == 3'h3) txOn <= 1'b1;
         if (rxDone && cmd == OP_GETF && idx != 3'h0) begin
            txReg <= featByte;
         end else if (rdStep) begin
            txReg <= rdData;
         end else if (sclkFall && txOn) begin
            txReg <= {txReg[6:0], 1'b0};
         end
         if (sclkFall && txOn) begin
            sioOut <= txReg[7];
            sioOe <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // AXI4-Lite slave.
   // ---------------------------------------------------------------
   assign wIdx = axiIdx(awAddr);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         awHave <= 1'b0;
         wHave <= 1'b0;
         awAddr <= 8'h00;
         wData <= 32'h0000_0000;
         wStrb <= 4'h0;
         uid <= UID_INIT;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awAddr <= s_axi_awaddr;
            awHave <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
            wHave <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (awHave && wHave && !s_axi_bvalid) begin
            awHave <= 1'b0;
            wHave <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wIdx == 3'h0 || wIdx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
            for (int b = 0; b < 4; b++) begin
               if (wIdx != 3'h0 && wIdx != IDX_NONE && wStrb[b]) begin
                  uid[{wIdx[1:0] - 2'h1, 5'h00} + 7'(8 * b) +: 8] <= wData[8 * b +: 8];
               end
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         unique case (axiIdx(s_axi_araddr))
            3'h0: s_axi_rdata <= {7'h00, otpSealed, lockReg, otpReg, stat};
            3'h1: s_axi_rdata <= uid[31:0];
            3'h2: s_axi_rdata <= uid[63:32];
            3'h3: s_axi_rdata <= uid[95:64];
            3'h4: s_axi_rdata <= uid[127:96];
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Assertions.
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   wel_clear_a: assert property (cmdByte && idle && rxByte == OP_WRITE_DIS |=> !write_latch_flag)
      else $error("Write disable left the latch set.");
   col_step_a: assert property (dataByte && col != 12'hFFF |=> col == $past(col) + 12'h001)
      else $error("Load column did not advance.");
   quad_gate_a: assert property (dataByte && quadPh |-> otpReg.quadIoEnable)
      else $error("Quad load taken without quad enable.");
   load_wel_a: assert property ($rose(loadOk) |-> $past(write_latch_flag) && $past(idle))
      else $error("Load armed without write latch.");
   cs_stop_a: assert property ($rose(csS[1]) |=> !loadOk && !sioOe && idx == 3'h0)
      else $error("Frame outlived chip select.");
   erase_busy_a: assert property (opCap && cmd == OP_ERASE && write_latch_flag && !rowLocked
      |=> state == ST_ERASE && stat.operationBusyFlag [*8])
      else $error("Erase did not stay busy.");
   erase_fail_a: assert property (opCap && cmd == OP_ERASE && write_latch_flag && rowLocked
      |=> stat.eraseFail && !write_latch_flag && idle)
      else $error("Locked erase did not report 04h.");
   guard_a: assert property (featWr && addrHi == FA_LOCK && lockReg.guard && !wpS[1]
      |=> $stable(lockReg))
      else $error("Guarded lock register changed.");
   finish_a: assert property ($rose(idle) && $past(state) != ST_READ |-> !write_latch_flag)
      else $error("Latch survived a finished operation.");
   busy_ignore_a: assert property (!idle && cmdByte && rxByte == OP_WRITE_EN && !write_latch_flag
      |=> !write_latch_flag)
      else $error("Write enable acted while busy.");
   seal_a: assert property (opCap && cmd == OP_EXEC && write_latch_flag && otpReg.access && otpSealed
      |=> pFail && idle)
      else $error("Sealed OTP accepted a program.");
endmodule // snpep_top

// ==== snpep_host_model.sv ====
// Purpose: Host side of the SPI link, sending command frames to the block.
// Assumes: Mode 0, single data line, 80 ns link clock, csN high 100 ns between frames.
// Notes: The link clock stands low outside frames; released data shows the inverse bit.
`timescale 1ns/10ps
module snpep_host_model (
   // SPI link.
   output logic csN,
   output logic sclk,
   output logic [3:0] sioIn,
   // Answer from the block.
   input logic sioOut,
   input logic sioOe
);
   // Last 32 bits seen on the answer line; a released line reads as the inverse.
   logic [31:0] rx;
   initial begin
      csN = 1'b1;
      sclk = 1'b0;
      sioIn = 4'h0;
      rx = 32'h0000_0000;
   end
   // Sends n bytes from the top of b, msb first, then raises csN to close the frame.
   // Bytes beyond the fourth are sent as zero, which serves dummy and read phases.
   task automatic frame(input logic [31:0] b, input int n);
      csN = 1'b0;
      rx = 32'h0000_0000;
      for (int k = 0; k < 8 * n; k++) begin
         #20 sioIn = {3'h0, k < 32 ? b[31 - k] : 1'b0};
         #20 sclk = 1'b1;
         rx = {rx[30:0], sioOe ? sioOut : ~sioOut};
         #40 sclk = 1'b0;
      end
      #40 csN = 1'b1;
      sioIn = ~sioIn;
      #100;
   endtask
endmodule // snpep_host_model

// ==== snpep_top_tb.sv ====
// Purpose: Self-checking bench for the SPI NAND program, erase and protect block.
// Assumes: Short busy counts; status is watched over the register bus.
// Notes: Program and erase busy counts are long enough that one command frame fits inside them.
`timescale 1ns/10ps
module snpep_top_tb;
   import snpep_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic wpN = 1'b1;
   logic csN, sclk, sioOut, sioOe, awR, wR, bV, arR, rV, iv, cp, lkd, er;
   logic [3:0] sioIn;
   logic [7:0] aw = 8'h00, ar = 8'h00;
   logic awV = 1'b0, wV = 1'b0, bR = 1'b0, arV = 1'b0, rR = 1'b0;
   logic [31:0] wd = 32'h0000_0000, rd, d, v;
   logic [1:0] br, rr, r;
   logic [2:0] rg;
   logic [15:0] row;
   logic [7:0] db, c0;
   logic ef = 1'b0, pf = 1'b0, cv = 1'b0;
   logic [7:0] ops [4] = '{OP_LOAD, OP_LOAD_Q, OP_RAND, OP_RAND_Q};
   int fails = 0;
   int checked = 0;
   always #4 mclk = ~mclk;
   snpep_host_model host (.csN(csN), .sclk(sclk), .sioIn(sioIn), .sioOut(sioOut), .sioOe(sioOe));
   snpep_top #(.PROG_CYCLES(200), .ERASE_CYCLES(300), .READ_CYCLES(10)) dut (
      .mclk(mclk), .rst(rst), .csN(csN), .sclk(sclk), .wpN(wpN), .sioIn(sioIn),
      .sioOut(sioOut), .sioOe(sioOe), .s_axi_awaddr(aw), .s_axi_awvalid(awV),
      .s_axi_awready(awR), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wV),
      .s_axi_wready(wR), .s_axi_bresp(br), .s_axi_bvalid(bV), .s_axi_bready(bR),
      .s_axi_araddr(ar), .s_axi_arvalid(arV), .s_axi_arready(arR), .s_axi_rdata(rd),
      .s_axi_rresp(rr), .s_axi_rvalid(rV), .s_axi_rready(rR));
   function automatic logic lk(input logic [2:0] g, input logic i, c, input logic [9:0] b);
      int n;
      n = 1024 >> (7 - g);
      if (g == 3'h0 || g == 3'h7) return g == 3'h7;
      if (c && g == 3'h6) return b == 10'h000;
      if (c) return i ? b >= n : b < 1024 - n;
      return i ? b < n : b >= 1024 - n;
   endfunction
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // A wait that used up its bound ends the run as a failure.
   task automatic bound(input int t);
      if (t >= 60) begin
         fails++;
         tally_and_finish();
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] x);
      int t = 0;
      @(posedge mclk);
      aw <= a;
      wd <= x;
      awV <= 1'b1;
      wV <= 1'b1;
      bR <= 1'b1;
      do begin
         @(posedge mclk);
         t++;
         if (awR) awV <= 1'b0;
         if (wR) wV <= 1'b0;
      end while (!bV && t < 60);
      bR <= 1'b0;
      r = br;
      bound(t);
   endtask
   task automatic axr(input logic [7:0] a);
      int t = 0;
      @(posedge mclk);
      ar <= a;
      arV <= 1'b1;
      rR <= 1'b1;
      do begin
         @(posedge mclk);
         t++;
         if (arR) arV <= 1'b0;
      end while (!rV && t < 60);
      rR <= 1'b0;
      d = rd;
      r = rr;
      bound(t);
   endtask
   task automatic chk(input logic [31:0] m, input logic [31:0] e);
      axr(A_STATUS);
      cmp(d & m, e);
   endtask
   task automatic idle();
      int t = 0;
      do begin
         axr(A_STATUS);
         t++;
      end while (d[0] !== 1'b0 && t < 200);
      bound(d[0] !== 1'b0 ? 60 : 0);
   endtask
   // Write enable, program execute to page w, then wait until the block is ready.
   task automatic wx(input logic [15:0] w);
      host.frame({OP_WRITE_EN, 24'h00_0000}, 1);
      host.frame({OP_EXEC, 8'h00, w}, 4);
      idle();
   endtask
   initial begin
      void'($urandom(32'hB46D_C60A));
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      chk(32'hFFFF_FFFF, 32'h003E_1000);
      v = $urandom();
      axw(A_UID0 + 8'h04, v);
      axr(A_UID0 + 8'h04);
      cmp(d, v);
      axr(8'h08);
      cmp({30'h0, r}, {30'h0, RESP_SLVERR});
      axw(A_STATUS, v);
      cmp({30'h0, r}, {30'h0, RESP_SLVERR});
      host.frame({OP_ERASE, 24'h00_0040}, 4);
      chk(32'h0000_00FF, 32'h0000_0000);
      host.frame({OP_WRITE_EN, 24'h00_0000}, 1);
      chk(32'h0000_00FF, 32'h0000_0002);
      host.frame({OP_WRITE_DIS, 24'h00_0000}, 1);
      chk(32'h0000_00FF, 32'h0000_0000);
      for (int k = 0; k < 14; k++) begin
         rg = 3'($urandom());
         iv = 1'($urandom());
         cp = 1'($urandom());
         row = 16'($urandom());
         if (k == 0) {rg, iv, cp, row} = {3'h6, 1'b1, 1'b1, 16'h0000};
         if (k == 1) {rg, iv, cp, row} = {3'h1, 1'b0, 1'b0, 16'hFFC0};
         lkd = lk(rg, iv, cp, row[15:6]);
         er = 1'($urandom());
         if (er) ef = lkd;
         else pf = lkd;
         host.frame({OP_SETF, FA_LOCK, 2'b00, rg, iv, cp, 1'b0, 8'h00}, 3);
         chk(32'h00FF_0000, {10'h000, rg, iv, cp, 17'h0_0000});
         host.frame({OP_GETF, FA_LOCK, 16'h0000}, 3);
         cmp(host.rx & 32'h0000_00FF, {26'h0, rg, iv, cp, 1'b0});
         if (!er) begin
            host.frame({OP_PREAD, 8'h00, row}, 4);
            idle();
         end
         host.frame({OP_WRITE_EN, 24'h00_0000}, 1);
         if (!er) begin
            db = 8'($urandom());
            host.frame({ops[k % 4], 16'h0000, db}, 4);
            if (ops[k % 4] inside {OP_LOAD, OP_RAND}) {cv, c0} = {1'b1, db};
            host.frame({OP_RDC, 24'h00_0000}, 5);
            if (cv) cmp(host.rx & 32'h0000_00FF, {24'h0, c0});
         end
         host.frame({er ? OP_ERASE : OP_EXEC, 8'h00, row}, 4);
         if (lkd) chk(32'h0000_00FF, {28'h0, pf, ef, 2'b00});
         else begin
            chk(32'h0000_0001, 32'h0000_0001);
            host.frame({OP_WRITE_EN, 24'h00_0000}, 1);
            idle();
            cmp(d & 32'h0000_00FF, {28'h0, pf, ef, 2'b00});
         end
      end
      host.frame({OP_SETF, FA_OTP, 8'h40, 8'h00}, 3);
      host.frame({OP_PREAD, 24'h00_0000}, 4);
      idle();
      host.frame({OP_RDC, 8'h00, 8'h04, 8'h00}, 5);
      cmp(host.rx & 32'h0000_00FF, {24'h0, v[7:0]});
      host.frame({OP_RDC, 8'h00, 8'h14, 8'h00}, 5);
      cmp(host.rx & 32'h0000_00FF, {24'h0, ~v[7:0]});
      wx(16'h0003);
      cmp(d & 32'h0000_000B, 32'h0000_0000);
      wx(16'h0002);
      cmp(d & 32'h0000_000B, 32'h0000_0008);
      host.frame({OP_SETF, FA_OTP, 8'hC0, 8'h00}, 3);
      wx(16'h0000);
      chk(32'h0100_000B, 32'h0100_0000);
      wx(16'h0004);
      cmp(d & 32'h0000_000B, 32'h0000_0008);
      host.frame({OP_SETF, FA_OTP, 8'h10, 8'h00}, 3);
      chk(32'h0000_FF00, 32'h0000_1000);
      host.frame({OP_SETF, FA_LOCK, 8'h80, 8'h00}, 3);
      @(posedge mclk);
      wpN <= 1'b0;
      host.frame({OP_SETF, FA_LOCK, 8'h3E, 8'h00}, 3);
      chk(32'h00FF_0000, 32'h0080_0000);
      tally_and_finish();
   end
endmodule // snpep_top_tb
